// *** iopw_top.sv ***
`timescale 1ns/100ps
`include "iopw_regs.svh"

module iopw_top
#(
    parameter int SOF_HIGH_CYCLES = `IOPW_SOF_HALF_CYC
)
(
    // clock and power-on reset
    input  wire logic                 sys_clk,
    input  wire logic                 srst,
    // register port
    input  wire iopw_pkg::iopw_addr_t reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire iopw_pkg::iopw_byte_t reg_wdata,
    output iopw_pkg::iopw_byte_t      reg_rdata,
    // pins
    input  wire logic [3:0]           general_input,
    input  wire logic                 vbus_detect_pin,
    input  wire logic                 positive_data_line,
    output logic [3:0]                general_output,
    output logic                      multipurpose_pin,
    output logic                      int_pin_out,
    output logic                      int_pin_oe_n,
    // bus engine side
    input  wire logic                 usb_bus_reset,
    input  wire logic                 sof_pulse,
    input  wire logic                 bus_activity,
    input  wire logic                 ep_zero_in_acked,
    input  wire logic                 ep_two_in_acked,
    input  wire logic                 other_irq_pending,
    output logic                      oscillator_enable,
    output logic                      bus_connect,
    output logic                      ep_two_in_armed,
    output iopw_pkg::iopw_count_t     ep_two_in_count
);

    import iopw_pkg::*;

    localparam int SOF_W = $clog2(SOF_HIGH_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [3:0] gin_s;
    logic       vbus_s;
    logic       dline_s;

    iopw_sync #(.W(6)) u_sync
    (
        .sys_clk (sys_clk),
        .srst    (srst),
        .d       ({general_input, vbus_detect_pin, positive_data_line}),
        .q       ({gin_s, vbus_s, dline_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic hit(input iopw_addr_t a, input iopw_addr_t ofs);
        hit = (a == ofs);
    endfunction : hit

    logic wr_pins;
    logic wr_pctl;
    logic wr_bctl;
    logic wr_cctl;
    logic wr_epen;
    logic wr_epfl;
    logic wr_bc0;
    logic wr_bc2;

    assign wr_pins = reg_wr & hit(reg_addr, `IOPW_OFS_PINS);
    assign wr_pctl = reg_wr & hit(reg_addr, `IOPW_OFS_PIN_CTL);
    assign wr_bctl = reg_wr & hit(reg_addr, `IOPW_OFS_BUS_CTL);
    assign wr_cctl = reg_wr & hit(reg_addr, `IOPW_OFS_CPU_CTL);
    assign wr_epen = reg_wr & hit(reg_addr, `IOPW_OFS_EP_ENABLES);
    assign wr_epfl = reg_wr & hit(reg_addr, `IOPW_OFS_EP_FLAGS);
    assign wr_bc0  = reg_wr & hit(reg_addr, `IOPW_OFS_EP0_BC);
    assign wr_bc2  = reg_wr & hit(reg_addr, `IOPW_OFS_EP2_IN_BC);

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    logic [3:0] gout_r;
    logic       sel_lo_r;
    logic       sel_hi_r;
    logic       int_rising_r;
    logic       int_level_r;
    logic       host_wake_enable_r;
    logic       vbgate_r;
    logic       chip_reset_r;
    logic       power_down_r;
    logic       connect_r;
    logic       resume_r;
    logic       master_en_r;
    logic       ep_zero_en_r;
    logic       ep_two_en_r;
    logic       any_reset;

    // chip reset is held for as long as software leaves its bit set
    assign any_reset = chip_reset_r | usb_bus_reset;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            gout_r <= `IOPW_RST_GOUT;
        else if (wr_pins)
            gout_r <= reg_wdata[`IOPW_PINS_OUT_LSB +: 4];
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sel_lo_r     <= `IOPW_RST_ZERO;
            sel_hi_r     <= `IOPW_RST_ZERO;
            int_rising_r <= `IOPW_RST_ZERO;
            int_level_r  <= `IOPW_RST_ZERO;
        end
        else if (wr_pctl)
        begin
            sel_lo_r     <= reg_wdata[`IOPW_PCTL_SEL_LO];
            sel_hi_r     <= reg_wdata[`IOPW_PCTL_SEL_HI];
            int_rising_r <= reg_wdata[`IOPW_PCTL_RISING];
            int_level_r  <= reg_wdata[`IOPW_PCTL_LEVEL];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            host_wake_enable_r <= `IOPW_RST_ZERO;
        else if (wr_bctl)
            host_wake_enable_r <= reg_wdata[`IOPW_BCTL_HOSTWAKE];
    end

    // the chip reset bit itself must survive its own reset
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            chip_reset_r <= `IOPW_RST_ZERO;
            vbgate_r     <= `IOPW_RST_ZERO;
            connect_r    <= `IOPW_RST_ZERO;
        end
        else if (wr_bctl)
        begin
            chip_reset_r <= reg_wdata[`IOPW_BCTL_CHIPRST];
            vbgate_r     <= reg_wdata[`IOPW_BCTL_VBGATE];
            connect_r    <= reg_wdata[`IOPW_BCTL_CONNECT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst || chip_reset_r)
        begin
            power_down_r <= `IOPW_RST_ZERO;
            resume_r     <= `IOPW_RST_ZERO;
        end
        else if (wr_bctl)
        begin
            power_down_r <= reg_wdata[`IOPW_BCTL_PWRDN];
            resume_r     <= reg_wdata[`IOPW_BCTL_RESUME];
        end
    end

    // interrupt enable, not touched by bus reset
    always_ff @(posedge sys_clk)
    begin
        if (srst || chip_reset_r)
            master_en_r <= `IOPW_RST_ZERO;
        else if (wr_cctl)
            master_en_r <= reg_wdata[`IOPW_CCTL_MASTER];
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst || any_reset)
        begin
            ep_zero_en_r <= `IOPW_RST_ZERO;
            ep_two_en_r  <= `IOPW_RST_ZERO;
        end
        else if (wr_epen)
        begin
            ep_zero_en_r <= reg_wdata[`IOPW_EP_ZERO_IN];
            ep_two_en_r  <= reg_wdata[`IOPW_EP_TWO_IN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // endpoint 0 IN

    logic        ep_zero_flag_r;
    iopw_count_t ep_zero_bc_r;

    // set by acked IN, wins over clear
    // write-one or byte count write clears
    always_ff @(posedge sys_clk)
    begin
        if (srst || any_reset)
            ep_zero_flag_r <= `IOPW_RST_FLAG;
        else if (ep_zero_in_acked)
            ep_zero_flag_r <= 1'b1;
        else if (wr_bc0 || (wr_epfl && reg_wdata[`IOPW_EP_ZERO_IN]))
            ep_zero_flag_r <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst || any_reset)
            ep_zero_bc_r <= '0;
        else if (wr_bc0)
            ep_zero_bc_r <= reg_wdata[6:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // endpoint 2 IN, two buffers

    iopw_count_t ep2_bc_r [2];
    logic        ep2_full_r [2];
    logic        ep2_load_ptr_r;
    logic        ep2_send_ptr_r;
    logic        ep_two_flag_r;
    logic        ep2_dip_r;
    logic        ep2_ack_ok;
    logic        ep2_wr_ok;
    logic        ep2_free_after;

    // an ack with nothing armed, or a load with both armed, is dropped
    assign ep2_ack_ok     = ep_two_in_acked & ep2_full_r[ep2_send_ptr_r];
    assign ep2_wr_ok      = wr_bc2 & ~ep2_full_r[ep2_load_ptr_r];
    assign ep2_free_after = ~ep2_full_r[~ep2_load_ptr_r] | ep2_ack_ok;

    always_ff @(posedge sys_clk)
    begin
        if (srst || any_reset)
        begin
            ep2_full_r[0]  <= 1'b0;
            ep2_full_r[1]  <= 1'b0;
            ep2_bc_r[0]    <= '0;
            ep2_bc_r[1]    <= '0;
            ep2_load_ptr_r <= 1'b0;
            ep2_send_ptr_r <= 1'b0;
        end
        else
        begin
            if (ep2_wr_ok)
            begin
                ep2_full_r[ep2_load_ptr_r] <= 1'b1;
                ep2_bc_r[ep2_load_ptr_r]   <= reg_wdata[6:0];
                ep2_load_ptr_r             <= ~ep2_load_ptr_r;
            end
            if (ep2_ack_ok)
            begin
                ep2_full_r[ep2_send_ptr_r] <= 1'b0;
                ep2_send_ptr_r             <= ~ep2_send_ptr_r;
            end
        end
    end

    // dip lasts one cycle, then the flag returns if a buffer is still free
    always_ff @(posedge sys_clk)
    begin
        if (srst || any_reset)
            ep2_dip_r <= 1'b0;
        else
            ep2_dip_r <= ep2_wr_ok & ep2_free_after;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst || any_reset)
            ep_two_flag_r <= `IOPW_RST_FLAG;
        else if (ep2_ack_ok)
            ep_two_flag_r <= 1'b1;
        else if (wr_bc2)
            ep_two_flag_r <= 1'b0;
        else if (ep2_dip_r)
            ep_two_flag_r <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst || any_reset)
        begin
            ep_two_in_armed <= 1'b0;
            ep_two_in_count <= '0;
        end
        else
        begin
            ep_two_in_armed <= ep2_full_r[ep2_send_ptr_r];
            ep_two_in_count <= ep2_bc_r[ep2_send_ptr_r];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator wake

    logic wake_r;

    // D+ wake gated by host wake enable
    // third restart source, D+ low with oscillator off
    always_ff @(posedge sys_clk)
    begin
        if (srst || !power_down_r)
            wake_r <= 1'b0;
        else if (host_wake_enable_r && !oscillator_enable && !dline_s)
            wake_r <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            oscillator_enable <= 1'b1;
        else
            oscillator_enable <= ~power_down_r | resume_r | wake_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            bus_connect <= 1'b0;
        else
            bus_connect <= connect_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // multipurpose pin

    iopw_sof_state_t  sof_state_r;
    logic [SOF_W-1:0] sof_cnt_r;
    logic             operate_r;
    iopw_mux_t        mux_sel;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            operate_r <= 1'b0;
        else
            operate_r <= 1'b1;
    end

    // rise on each frame start, fall after half a frame
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sof_state_r <= IOPW_SOF_LOW;
            sof_cnt_r   <= '0;
        end
        else
        begin
            case (sof_state_r)
                IOPW_SOF_LOW:
                begin
                    if (sof_pulse)
                    begin
                        sof_state_r <= IOPW_SOF_HIGH;
                        sof_cnt_r   <= SOF_W'(SOF_HIGH_CYCLES - 1);
                    end
                end
                IOPW_SOF_HIGH:
                begin
                    if (sof_pulse)
                        sof_cnt_r <= SOF_W'(SOF_HIGH_CYCLES - 1);
                    else if (sof_cnt_r == '0)
                        sof_state_r <= IOPW_SOF_LOW;
                    else
                        sof_cnt_r <= sof_cnt_r - 1'b1;
                end
                default:
                    sof_state_r <= IOPW_SOF_LOW;
            endcase
        end
    end

    assign mux_sel = iopw_mux_t'({sel_hi_r, sel_lo_r});

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            multipurpose_pin <= 1'b0;
        else
        begin
            case (mux_sel)
                IOPW_MUX_OPERATE: multipurpose_pin <= operate_r;
                IOPW_MUX_VBUS:    multipurpose_pin <= vbus_s;
                IOPW_MUX_ACTIVE:  multipurpose_pin <= bus_activity;
                IOPW_MUX_SOF:     multipurpose_pin <= (sof_state_r == IOPW_SOF_HIGH);
                default:          multipurpose_pin <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt pin, level of pending only; edge pulse shaping lives elsewhere

    logic pending;

    assign pending = (ep_zero_flag_r & ep_zero_en_r) | (ep_two_flag_r & ep_two_en_r)
                   | other_irq_pending;

    // inactive level while master enable is clear
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            int_pin_out  <= 1'b0;
            int_pin_oe_n <= 1'b1;
        end
        else if (int_level_r)
        begin
            int_pin_out  <= 1'b0;
            int_pin_oe_n <= ~(master_en_r & pending);
        end
        else
        begin
            int_pin_out  <= (master_en_r & pending) ? int_rising_r : ~int_rising_r;
            int_pin_oe_n <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs and read-back

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            general_output <= `IOPW_RST_GOUT;
        else
            general_output <= gout_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                `IOPW_OFS_PINS:       reg_rdata <= {gin_s, gout_r};
                `IOPW_OFS_PIN_CTL:    reg_rdata <= {4'h0, int_level_r, int_rising_r,
                                                    sel_hi_r, sel_lo_r};
                `IOPW_OFS_BUS_CTL:    reg_rdata <= {host_wake_enable_r, vbgate_r,
                                                    chip_reset_r, power_down_r,
                                                    connect_r, resume_r, 2'h0};
                `IOPW_OFS_CPU_CTL:    reg_rdata <= {7'h00, master_en_r};
                `IOPW_OFS_EP_ENABLES: reg_rdata <= {4'h0, ep_two_en_r, 2'h0, ep_zero_en_r};
                `IOPW_OFS_EP_FLAGS:   reg_rdata <= {4'h0, ep_two_flag_r, 2'h0, ep_zero_flag_r};
                `IOPW_OFS_EP0_BC:     reg_rdata <= {1'b0, ep_zero_bc_r};
                `IOPW_OFS_EP2_IN_BC:  reg_rdata <= {1'b0, ep2_bc_r[ep2_send_ptr_r]};
                default:              reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule : iopw_top

// *** iopw_regs.svh ***
`ifndef IOPW_REGS_SVH
`define IOPW_REGS_SVH

// register indices on the register port
`define IOPW_OFS_EP0_BC      5'h05
`define IOPW_OFS_EP2_IN_BC   5'h07
`define IOPW_OFS_EP_FLAGS    5'h0B
`define IOPW_OFS_EP_ENABLES  5'h0C
`define IOPW_OFS_BUS_CTL     5'h0F
`define IOPW_OFS_CPU_CTL     5'h10
`define IOPW_OFS_PIN_CTL     5'h11
`define IOPW_OFS_PINS        5'h14

// general_pin_levels fields
`define IOPW_PINS_OUT_LSB    0
`define IOPW_PINS_IN_LSB     4

// pin_function_control fields
`define IOPW_PCTL_SEL_LO     0
`define IOPW_PCTL_SEL_HI     1
`define IOPW_PCTL_RISING     2
`define IOPW_PCTL_LEVEL      3

// bus_control fields
`define IOPW_BCTL_RESUME     2
`define IOPW_BCTL_CONNECT    3
`define IOPW_BCTL_PWRDN      4
`define IOPW_BCTL_CHIPRST    5
`define IOPW_BCTL_VBGATE     6
`define IOPW_BCTL_HOSTWAKE   7

// processor_interrupt_control fields
`define IOPW_CCTL_MASTER     0

// endpoint enable and flag fields
`define IOPW_EP_ZERO_IN      0
`define IOPW_EP_TWO_IN       3

// reset values
`define IOPW_RST_GOUT        4'h0
`define IOPW_RST_FLAG        1'b1
`define IOPW_RST_ZERO        1'b0

// timing: half of a 1 ms frame at sys_clk rate
`define IOPW_CLK_MHZ         20
`define IOPW_SOF_HALF_US     500
`define IOPW_SOF_HALF_CYC    (`IOPW_SOF_HALF_US * `IOPW_CLK_MHZ)

`endif

// *** iopw_pkg.sv ***
package iopw_pkg;

    typedef logic [7:0] iopw_byte_t;
    typedef logic [4:0] iopw_addr_t;
    typedef logic [6:0] iopw_count_t;

    // multipurpose pin source, high select bit first
    typedef enum logic [1:0]
    {
        IOPW_MUX_OPERATE = 2'h0,
        IOPW_MUX_VBUS    = 2'h1,
        IOPW_MUX_ACTIVE  = 2'h2,
        IOPW_MUX_SOF     = 2'h3
    } iopw_mux_t;

    // sof square wave generator
    typedef enum
    {
        IOPW_SOF_LOW,
        IOPW_SOF_HIGH
    } iopw_sof_state_t;

endpackage : iopw_pkg

// *** iopw_sync.sv ***
`timescale 1ns/100ps

module iopw_sync
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         srst,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;
    // first stage feeds only the second stage
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            meta_r <= '1;
            q      <= '1;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : iopw_sync

// *** iopw_monitor.sv ***
`timescale 1ns/100ps
`include "iopw_regs.svh"

module iopw_monitor
#(
    parameter int SOF_HIGH_CYCLES = 8
)
(
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  srst,
    // register port
    input wire iopw_pkg::iopw_addr_t  reg_addr,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire iopw_pkg::iopw_byte_t  reg_wdata,
    input wire iopw_pkg::iopw_byte_t  reg_rdata,
    // pins and bus engine side
    input wire logic [3:0]            general_output,
    input wire logic                  multipurpose_pin,
    input wire logic                  usb_bus_reset,
    input wire logic                  ep_zero_in_acked,
    input wire logic                  oscillator_enable,
    input wire logic                  ep_two_in_armed,
    input wire iopw_pkg::iopw_count_t ep_two_in_count
);
    import iopw_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic       wr_pins = reg_wr && reg_addr == `IOPW_OFS_PINS;
    wire logic       wr_bctl = reg_wr && reg_addr == `IOPW_OFS_BUS_CTL;
    wire logic [3:0] gout_w  = reg_wdata[3:0];
    wire logic [6:0] cnt_w   = reg_wdata[6:0];
    ////////////////////////////////////////////////////////////////////////////////
    // output pin, read-back, endpoint and oscillator checks
    out_follow_a: assert property (wr_pins |-> ##2 general_output == $past(gout_w, 2))
        else $error("general output differs from written value");
    gout_hold_a: assert property (!$stable(general_output) && !$past(srst) |-> $past(wr_pins, 2))
        else $error("general output moved without a write");
    unmapped_read_a: assert property (reg_rd && reg_addr == 5'h1F |=> reg_rdata == 8'h00)
        else $error("unmapped index read not zero");
    ep0_set_a: assert property (ep_zero_in_acked ##1 !reg_wr ##1 (reg_rd
        && reg_addr == `IOPW_OFS_EP_FLAGS) |=> reg_rdata[`IOPW_EP_ZERO_IN])
        else $error("endpoint zero flag not set after ack");
    ep2_arm_a: assert property (!ep_two_in_armed && !$past(reg_wr) && reg_wr
        && reg_addr == `IOPW_OFS_EP2_IN_BC && !usb_bus_reset ##1 !usb_bus_reset
        |=> ep_two_in_armed && ep_two_in_count == $past(cnt_w, 2))
        else $error("endpoint two count write did not arm");
    busrst_clr_a: assert property (usb_bus_reset |=> !ep_two_in_armed && ep_two_in_count == 7'h00)
        else $error("bus reset left endpoint two armed");
    osc_run_a: assert property (wr_bctl && !reg_wdata[`IOPW_BCTL_PWRDN] |-> ##2 oscillator_enable)
        else $error("oscillator off after power down cleared");
    osc_resume_a: assert property (wr_bctl && reg_wdata[`IOPW_BCTL_RESUME] |=> ##1 oscillator_enable)
        else $error("oscillator off after resume set");
    ////////////////////////////////////////////////////////////////////////////////
    cover property (ep_zero_in_acked);
    cover property (usb_bus_reset ##1 !usb_bus_reset);
    cover property ($rose(multipurpose_pin));
endmodule : iopw_monitor

bind iopw_top iopw_monitor #(.SOF_HIGH_CYCLES(SOF_HIGH_CYCLES)) iopw_monitor_i (.sys_clk, .srst,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .general_output, .multipurpose_pin,
    .usb_bus_reset, .ep_zero_in_acked, .oscillator_enable, .ep_two_in_armed, .ep_two_in_count);

// *** iopw_host.sv ***
`timescale 1ns/100ps

module iopw_host
(
    // clock
    input  wire logic                 sys_clk,
    // register port
    output iopw_pkg::iopw_addr_t      reg_addr,
    output logic                      reg_wr,
    output logic                      reg_rd,
    output iopw_pkg::iopw_byte_t      reg_wdata,
    input  wire iopw_pkg::iopw_byte_t reg_rdata
);
    import iopw_pkg::*;
    initial
    begin
        reg_addr  = 5'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // released data shows the inverse
    task automatic wr(input iopw_addr_t a, input iopw_byte_t d);
        @(posedge sys_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input iopw_addr_t a, output iopw_byte_t d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        @(posedge sys_clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : iopw_host

// *** test_io_pins_wake_and_in_buffer_flags.sv ***
`timescale 1ns/100ps
`include "iopw_regs.svh"

module test_io_pins_wake_and_in_buffer_flags;
    import iopw_pkg::*;
    localparam int SOF_CYC = 8;
    // {level, rising, enable, 0, expected {oe_n, out}, mask}
    localparam logic [7:0] ITAB [6] = '{8'hA3, 8'h8A, 8'h43, 8'h67, 8'h07, 8'h23};
    logic        sys_clk, srst, reg_wr, reg_rd, vbus_detect_pin, positive_data_line;
    logic        multipurpose_pin, int_pin_out, int_pin_oe_n, usb_bus_reset, sof_pulse;
    logic        bus_activity, ep_zero_in_acked, ep_two_in_acked, other_irq_pending;
    logic        oscillator_enable, bus_connect, ep_two_in_armed;
    logic [3:0]  general_input, general_output;
    iopw_addr_t  reg_addr;
    iopw_byte_t  reg_wdata, reg_rdata, d;
    iopw_count_t ep_two_in_count;
    int          failures, comparisons;

    iopw_top #(.SOF_HIGH_CYCLES(SOF_CYC)) iopw_top_i (.sys_clk, .srst, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .general_input, .vbus_detect_pin, .positive_data_line,
        .general_output, .multipurpose_pin, .int_pin_out, .int_pin_oe_n, .usb_bus_reset,
        .sof_pulse, .bus_activity, .ep_zero_in_acked, .ep_two_in_acked, .other_irq_pending,
        .oscillator_enable, .bus_connect, .ep_two_in_armed, .ep_two_in_count);
    iopw_host iopw_host_i (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input string n, input iopw_addr_t a, input iopw_byte_t m, input iopw_byte_t e);
        iopw_host_i.rd(a, d);
        chk(n, e, d & m);
    endtask : rchk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic pulse(ref logic s);
        @(posedge sys_clk);
        #1;
        s = 1'b1;
        @(posedge sys_clk);
        #1;
        s = 1'b0;
    endtask : pulse
    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // run takes about two hundred cycles
    initial
    begin
        #200000;
        failures++;
        wrap_up();
    end
    initial
    begin
        {srst, usb_bus_reset, sof_pulse, ep_zero_in_acked, ep_two_in_acked} = 5'h10;
        {vbus_detect_pin, bus_activity, other_irq_pending, positive_data_line} = 4'h7;
        general_input = 4'hA;
        failures = 0;
        comparisons = 0;
        repeat (3) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        cyc(3);
        rchk("flags", `IOPW_OFS_EP_FLAGS, 8'h09, 8'h09);
        rchk("enables", `IOPW_OFS_EP_ENABLES, 8'h09, 8'h00);
        rchk("pins", `IOPW_OFS_PINS, 8'hFF, 8'hA0);
        rchk("unmapped", 5'h1F, 8'hFF, 8'h00);
        iopw_host_i.wr(`IOPW_OFS_PINS, 8'hF5);
        cyc(1);
        chk("output pins", 8'h05, {4'h0, general_output});
        general_input = 4'h3;
        cyc(3);
        rchk("pins", `IOPW_OFS_PINS, 8'hFF, 8'h35);
        $display("test reset and pins done");
        for (int s = 0; s < 3; s++)
        begin
            iopw_host_i.wr(`IOPW_OFS_PIN_CTL, 8'(s));
            cyc(4);
            chk("multipurpose pin", {7'h00, s != 1}, {7'h00, multipurpose_pin});
        end
        iopw_host_i.wr(`IOPW_OFS_PIN_CTL, 8'h03);
        pulse(sof_pulse);
        cyc(2);
        chk("frame pin high", 8'h01, {7'h00, multipurpose_pin});
        cyc(SOF_CYC + 2);
        chk("frame pin low", 8'h00, {7'h00, multipurpose_pin});
        $display("test multipurpose pin done");
        // chip reset: wake enable kept, interrupt enable and endpoint enables cleared
        iopw_host_i.wr(`IOPW_OFS_CPU_CTL, 8'h01);
        iopw_host_i.wr(`IOPW_OFS_EP_ENABLES, 8'h09);
        iopw_host_i.wr(`IOPW_OFS_BUS_CTL, 8'hA0);
        iopw_host_i.wr(`IOPW_OFS_BUS_CTL, 8'h80);
        rchk("interrupt enable", `IOPW_OFS_CPU_CTL, 8'h01, 8'h00);
        rchk("enables", `IOPW_OFS_EP_ENABLES, 8'h09, 8'h00);
        rchk("wake enable", `IOPW_OFS_BUS_CTL, 8'h80, 8'h80);
        rchk("select", `IOPW_OFS_PIN_CTL, 8'h03, 8'h03);
        rchk("pins", `IOPW_OFS_PINS, 8'h0F, 8'h05);
        iopw_host_i.wr(`IOPW_OFS_CPU_CTL, 8'h01);
        iopw_host_i.wr(`IOPW_OFS_EP_ENABLES, 8'h09);
        pulse(usb_bus_reset);
        rchk("interrupt enable", `IOPW_OFS_CPU_CTL, 8'h01, 8'h01);
        rchk("enables", `IOPW_OFS_EP_ENABLES, 8'h09, 8'h00);
        rchk("wake enable", `IOPW_OFS_BUS_CTL, 8'h80, 8'h80);
        rchk("select", `IOPW_OFS_PIN_CTL, 8'h03, 8'h03);
        rchk("pins", `IOPW_OFS_PINS, 8'h0F, 8'h05);
        iopw_host_i.wr(`IOPW_OFS_EP_ENABLES, 8'h09);
        $display("test resets done");
        for (int i = 0; i < 6; i++)
        begin
            iopw_host_i.wr(`IOPW_OFS_PIN_CTL, {4'h0, ITAB[i][7:6], 2'h3});
            iopw_host_i.wr(`IOPW_OFS_CPU_CTL, {7'h00, ITAB[i][5]});
            cyc(2);
            chk("interrupt pin", {6'h00, ITAB[i][3:2]},
                {6'h00, {int_pin_oe_n, int_pin_out} & ITAB[i][1:0]});
        end
        $display("test interrupt pin done");
        iopw_host_i.wr(`IOPW_OFS_EP0_BC, 8'h08);
        rchk("ep0 flag", `IOPW_OFS_EP_FLAGS, 8'h01, 8'h00);
        pulse(ep_zero_in_acked);
        rchk("ep0 flag", `IOPW_OFS_EP_FLAGS, 8'h01, 8'h01);
        iopw_host_i.wr(`IOPW_OFS_EP_FLAGS, 8'h01);
        rchk("ep0 flag", `IOPW_OFS_EP_FLAGS, 8'h01, 8'h00);
        iopw_host_i.wr(`IOPW_OFS_EP2_IN_BC, 8'h40);
        iopw_host_i.wr(`IOPW_OFS_EP_FLAGS, 8'h08);
        rchk("ep2 flag", `IOPW_OFS_EP_FLAGS, 8'h08, 8'h08);
        iopw_host_i.wr(`IOPW_OFS_EP2_IN_BC, 8'h11);
        rchk("ep2 flag", `IOPW_OFS_EP_FLAGS, 8'h08, 8'h00);
        chk("ep2 count", 8'hC0, {ep_two_in_armed, ep_two_in_count});
        pulse(ep_two_in_acked);
        rchk("ep2 flag", `IOPW_OFS_EP_FLAGS, 8'h08, 8'h08);
        chk("ep2 count", 8'h91, {ep_two_in_armed, ep_two_in_count});
        // level mode, only the endpoint two flag pending
        other_irq_pending = 1'b0;
        iopw_host_i.wr(`IOPW_OFS_PIN_CTL, 8'h0B);
        cyc(2);
        chk("gated request", 8'h00, {7'h00, int_pin_oe_n});
        iopw_host_i.wr(`IOPW_OFS_EP_ENABLES, 8'h00);
        cyc(2);
        chk("gated request", 8'h01, {7'h00, int_pin_oe_n});
        $display("test endpoint flags done");
        iopw_host_i.wr(`IOPW_OFS_BUS_CTL, 8'h10);
        cyc(2);
        chk("oscillator", 8'h00, {7'h00, oscillator_enable});
        chk("connect", 8'h00, {7'h00, bus_connect});
        positive_data_line = 1'b0;
        cyc(4);
        chk("oscillator", 8'h00, {7'h00, oscillator_enable});
        iopw_host_i.wr(`IOPW_OFS_BUS_CTL, 8'h98);
        cyc(5);
        chk("oscillator", 8'h01, {7'h00, oscillator_enable});
        chk("connect", 8'h01, {7'h00, bus_connect});
        positive_data_line = 1'b1;
        iopw_host_i.wr(`IOPW_OFS_BUS_CTL, 8'h08);
        iopw_host_i.wr(`IOPW_OFS_BUS_CTL, 8'h18);
        cyc(2);
        chk("oscillator", 8'h00, {7'h00, oscillator_enable});
        iopw_host_i.wr(`IOPW_OFS_BUS_CTL, 8'h1C);
        cyc(2);
        chk("oscillator", 8'h01, {7'h00, oscillator_enable});
        $display("test oscillator done");
        wrap_up();
    end
endmodule : test_io_pins_wake_and_in_buffer_flags
